//--- logic/evt_ctrl.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - configuration and control registers are read and write
// - status registers are read-only, showing current state
// - event registers are read-only and clear when read, except flags set again in the same cycle
// - missed-frame and collision counters clear on read; reflectometer value follows hardware
// - four act-once bits at bit 6 pulse once and read as zero
// - line, self and bus status bits follow hardware only
// - destination and first-128 flags set by hardware, cleared by read
// - interrupt raised when an enabled event occurs
// - event flags set regardless of their enables
// - receive config holds enables for extra, runt, crc, good frame
// - transmit config holds enables for the seven transmit events
// - buffer config holds enables for the eight buffer events, counter overflows included
// - counters interrupt on passing 1ffh when overflow enable set
// - four class accept bits in receive control choose accepted frames
// - accept and interrupt enable bits act independently
// - enabled but not accepted frame interrupts, is dropped, length zero
// - five remaining accept bits steer destination address filtering
// - counters and reflectometer are ten bits wide
// - bits 5:0 hold register id; bit 0 set for config words
module evt_ctrl
	import evt_pkg::*;
(
	// clock and reset
	input  wire logic              clock_i,
	input  wire logic              srst_i,
	// avalon-mm slave
	input  wire logic [7:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic [31:0]            avs_readdata,
	output logic                   avs_waitrequest,
	// events from the mac engine, same clock
	input  wire rx_evt_s           rx_evt_i,
	input  wire tx_evt_s           tx_evt_i,
	input  wire buf_evt_s          buf_evt_i,
	input  wire logic              missed_frame_i,
	input  wire logic              collision_i,
	input  wire logic [CNT_W-1:0]  cable_reflectometer_i,
	input  wire logic [9:0]        line_status_i,
	input  wire logic [9:0]        self_status_i,
	input  wire logic [9:0]        bus_status_i,
	// frame acceptance
	input  wire logic              rx_frame_done_i,
	input  wire logic [15:0]       rx_frame_len_i,
	output logic                   rx_accept_o,
	output logic [15:0]            rx_len_o,
	output logic [FILT_W-1:0]      addr_filter_accept_o,
	// actions
	output logic                   tx_start_o,
	output logic [15:0]            tx_command_o,
	output logic                   frame_skip_o,
	output logic                   chip_reset_o,
	output logic                   receive_dma_restart_o,
	// interrupt
	output logic                   irq_o
);

	//////////////////////////////////////////////////////////////////////////
	// bus request decode

	bus_req_s req;
	logic     ack_r, wait_r;

	assign req.rd    = avs_read && !ack_r;
	assign req.wr    = avs_write && !ack_r;
	assign req.addr  = avs_address;
	assign req.wdata = avs_writedata[15:0];

	// lanes 0 and 1 carry the 16-bit word; upper lanes are ignored
	wire [15:0] lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	wire wr_rx_cfg   = req.wr && hit(req.addr, OFF_RX_CFG);
	wire wr_rx_ctl   = req.wr && hit(req.addr, OFF_RX_CTL);
	wire wr_tx_cfg   = req.wr && hit(req.addr, OFF_TX_CFG);
	wire wr_buf_cfg  = req.wr && hit(req.addr, OFF_BUF_CFG);
	wire wr_self_ctl = req.wr && hit(req.addr, OFF_SELF_CTL);
	wire wr_bus_ctl  = req.wr && hit(req.addr, OFF_BUS_CTL);
	wire wr_tx_cmd   = req.wr && hit(req.addr, OFF_TX_CMD);
	wire rd_rx_evt   = req.rd && hit(req.addr, OFF_RX_EVT);
	wire rd_tx_evt   = req.rd && hit(req.addr, OFF_TX_EVT);
	wire rd_buf_evt  = req.rd && hit(req.addr, OFF_BUF_EVT);
	wire rd_miss     = req.rd && hit(req.addr, OFF_MISS_CNT);
	wire rd_col      = req.rd && hit(req.addr, OFF_COL_CNT);

	//////////////////////////////////////////////////////////////////////////
	// configuration and control bits 15:6

	logic [9:0] rx_cfg_r, tx_cfg_r, buf_cfg_r, rx_ctl_r, self_ctl_r, bus_ctl_r;
	logic [15:0] tx_cmd_r;

	function automatic logic [9:0] merge(input logic [9:0] old, input logic [15:0] d,
		input logic [15:0] m);
		return (old & ~m[15:6]) | (d[15:6] & m[15:6]);
	endfunction

	// act-once positions never stored, so they always read zero
	localparam logic [9:0] KEEP = ~(10'h001 << (ACT_ONCE_BIT - 6));
	wire [9:0] rx_cfg_nxt   = merge(rx_cfg_r, req.wdata, lane_mask) & KEEP;
	wire [9:0] buf_cfg_nxt  = merge(buf_cfg_r, req.wdata, lane_mask) & KEEP;
	wire [9:0] self_ctl_nxt = merge(self_ctl_r, req.wdata, lane_mask) & KEEP;
	wire [9:0] bus_ctl_nxt  = merge(bus_ctl_r, req.wdata, lane_mask) & KEEP;
	wire [9:0] tx_cfg_nxt   = merge(tx_cfg_r, req.wdata, lane_mask);
	wire [9:0] rx_ctl_nxt   = merge(rx_ctl_r, req.wdata & RX_CTL_MASK, lane_mask);

	// writable setup registers
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			rx_cfg_r   <= CFG_RST;
			tx_cfg_r   <= CFG_RST;
			buf_cfg_r  <= CFG_RST;
			rx_ctl_r   <= CFG_RST;
			self_ctl_r <= CFG_RST;
			bus_ctl_r  <= CFG_RST;
			tx_cmd_r   <= 16'h0000;
		end else begin
			if (wr_rx_cfg)   rx_cfg_r   <= rx_cfg_nxt;
			if (wr_tx_cfg)   tx_cfg_r   <= tx_cfg_nxt;
			if (wr_buf_cfg)  buf_cfg_r  <= buf_cfg_nxt;
			if (wr_rx_ctl)   rx_ctl_r   <= rx_ctl_nxt;
			if (wr_self_ctl) self_ctl_r <= self_ctl_nxt;
			if (wr_bus_ctl)  bus_ctl_r  <= bus_ctl_nxt;
			if (wr_tx_cmd)   tx_cmd_r   <= req.wdata;
		end
	end

	// act-once pulses, one cycle per write of a one; tx start pulses on every command write
	wire act_lane = avs_byteenable[0];
	logic skip_r, chip_rst_r, dma_rst_r, swint_r, tx_start_r;
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			skip_r     <= 1'b0;
			chip_rst_r <= 1'b0;
			dma_rst_r  <= 1'b0;
			swint_r    <= 1'b0;
			tx_start_r <= 1'b0;
		end else begin
			skip_r     <= wr_rx_cfg && act_lane && req.wdata[ACT_ONCE_BIT];
			chip_rst_r <= wr_self_ctl && act_lane && req.wdata[ACT_ONCE_BIT];
			dma_rst_r  <= wr_bus_ctl && act_lane && req.wdata[ACT_ONCE_BIT];
			swint_r    <= wr_buf_cfg && act_lane && req.wdata[ACT_ONCE_BIT];
			tx_start_r <= wr_tx_cmd;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// event flags: set wins over the read-clear

	logic [9:0] rx_evt_r, tx_evt_r, buf_evt_r;
	logic [9:0] rx_set, tx_set, buf_set;
	logic       miss_ovf, col_ovf;

	// map incoming pulses onto their bit positions
	always_comb begin
		rx_set = '0;
		rx_set[RX_EXTRA-6] = rx_evt_i.extra;
		rx_set[RX_RUNT-6]  = rx_evt_i.runt;
		rx_set[RX_CRC-6]   = rx_evt_i.crc;
		rx_set[RX_OK-6]    = rx_evt_i.ok;
		tx_set = '0;
		tx_set[TX_16C-6]   = tx_evt_i.sixteen;
		tx_set[TX_ANYC-6]  = tx_evt_i.anycol;
		tx_set[TX_JAB-6]   = tx_evt_i.jabber;
		tx_set[TX_LATE-6]  = tx_evt_i.late;
		tx_set[TX_OK-6]    = tx_evt_i.ok;
		tx_set[TX_HBEAT-6] = tx_evt_i.hbeat;
		tx_set[TX_CARR-6]  = tx_evt_i.carrier;
		buf_set = '0;
		buf_set[BF_DEST-6] = buf_evt_i.dest;
		buf_set[BF_128-6]  = buf_evt_i.first128;
		buf_set[BF_MISS-6] = buf_evt_i.missed;
		buf_set[BF_UNDR-6] = buf_evt_i.underrun;
		buf_set[BF_RDY-6]  = buf_evt_i.rdy;
		buf_set[BF_DMA-6]  = buf_evt_i.dma;
		buf_set[BF_MOVF-6] = miss_ovf;
		buf_set[BF_COVF-6] = col_ovf;
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			rx_evt_r  <= '0;
			tx_evt_r  <= '0;
			buf_evt_r <= '0;
		end else begin
			rx_evt_r  <= (rd_rx_evt ? '0 : rx_evt_r) | rx_set;
			tx_evt_r  <= (rd_tx_evt ? '0 : tx_evt_r) | tx_set;
			buf_evt_r <= (rd_buf_evt ? '0 : buf_evt_r) | buf_set;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// clear-on-read counters

	logic [CNT_W-1:0] miss_cnt, col_cnt;

	evt_counter #(.W(CNT_W)) u_miss (
		.clock_i (clock_i),
		.srst_i  (srst_i),
		.inc_i   (missed_frame_i),
		.clr_i   (rd_miss),
		.count_o (miss_cnt),
		.ovf_o   (miss_ovf)
	);

	evt_counter #(.W(CNT_W)) u_col (
		.clock_i (clock_i),
		.srst_i  (srst_i),
		.inc_i   (collision_i),
		.clr_i   (rd_col),
		.count_o (col_cnt),
		.ovf_o   (col_ovf)
	);

	//////////////////////////////////////////////////////////////////////////
	// read mux: bits 15:6 data, 5:0 identification

	function automatic logic [15:0] word(input logic [9:0] d, input logic [5:0] id);
		return {d, id};
	endfunction

	function automatic logic [15:0] cnt_word(input logic [CNT_W-1:0] c,
		input logic [5:0] id);
		return {c, id};
	endfunction

	logic [15:0] rd_word;
	always_comb begin
		if (hit(req.addr, OFF_RX_CFG))        rd_word = word(rx_cfg_r, ID_RX_CFG);
		else if (hit(req.addr, OFF_RX_EVT))   rd_word = word(rx_evt_r, ID_RX_EVT);
		else if (hit(req.addr, OFF_RX_CTL))   rd_word = word(rx_ctl_r, ID_RX_CTL);
		else if (hit(req.addr, OFF_TX_CFG))   rd_word = word(tx_cfg_r, ID_TX_CFG);
		else if (hit(req.addr, OFF_TX_EVT))   rd_word = word(tx_evt_r, ID_TX_EVT);
		else if (hit(req.addr, OFF_BUF_CFG))  rd_word = word(buf_cfg_r, ID_BUF_CFG);
		else if (hit(req.addr, OFF_BUF_EVT))  rd_word = word(buf_evt_r, ID_BUF_EVT);
		else if (hit(req.addr, OFF_MISS_CNT)) rd_word = cnt_word(miss_cnt, ID_MISS_CNT);
		else if (hit(req.addr, OFF_COL_CNT))  rd_word = cnt_word(col_cnt, ID_COL_CNT);
		else if (hit(req.addr, OFF_TDR))      rd_word = cnt_word(cable_reflectometer_i, ID_TDR);
		else if (hit(req.addr, OFF_LINE_ST))  rd_word = word(line_status_i, ID_LINE_ST);
		else if (hit(req.addr, OFF_SELF_CTL)) rd_word = word(self_ctl_r, ID_SELF_CTL);
		else if (hit(req.addr, OFF_SELF_ST))  rd_word = word(self_status_i, ID_SELF_ST);
		else if (hit(req.addr, OFF_BUS_CTL))  rd_word = word(bus_ctl_r, ID_BUS_CTL);
		else if (hit(req.addr, OFF_BUS_ST))   rd_word = word(bus_status_i, ID_BUS_ST);
		else if (hit(req.addr, OFF_TX_CMD))   rd_word = {tx_cmd_r[15:6], ID_TX_CMD};
		else                                  rd_word = 16'h0000;
	end

	// one wait cycle, then ack; writes to status words are ignored
	// waitrequest idles high so that it can come straight from a flop
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			ack_r        <= 1'b0;
			wait_r       <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else begin
			ack_r  <= req.rd || req.wr;
			wait_r <= !(req.rd || req.wr);
			if (req.rd) avs_readdata <= {16'h0000, rd_word};
		end
	end
	assign avs_waitrequest = wait_r;

	//////////////////////////////////////////////////////////////////////////
	// frame acceptance: class accept and interrupt enable act independently

	wire [9:0] rx_class = rx_evt_i.ok ? (10'h001 << (RX_OK-6)) :
		{1'b0, rx_evt_i.extra, rx_evt_i.runt, rx_evt_i.crc, 6'h00};
	wire       acc_now  = |(rx_class & rx_ctl_r);

	logic acc_r;
	logic [15:0] len_r;
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			acc_r <= 1'b0;
			len_r <= 16'h0000;
		end else if (rx_frame_done_i) begin
			acc_r <= acc_now;
			len_r <= acc_now ? rx_frame_len_i : 16'h0000;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// interrupt: or of enabled sticky flags, held until read clear, and the one-cycle software pulse

	wire irq_nxt = |(rx_evt_r & rx_cfg_r) | |(tx_evt_r & tx_cfg_r) |
		|(buf_evt_r & buf_cfg_r) | swint_r;
	// filter accepts skip bit 8, which is the good-frame class accept
	wire [FILT_W-1:0] filt_sel = {rx_ctl_r[5:3], rx_ctl_r[1:0]};
	logic irq_r;
	logic [FILT_W-1:0] filt_r;
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			irq_r  <= 1'b0;
			filt_r <= '0;
		end else begin
			irq_r  <= irq_nxt;
			filt_r <= filt_sel;
		end
	end

	// outputs straight from flip-flops
	assign rx_accept_o           = acc_r;
	assign rx_len_o              = len_r;
	assign addr_filter_accept_o  = filt_r;
	assign tx_start_o            = tx_start_r;
	assign tx_command_o          = tx_cmd_r;
	assign frame_skip_o          = skip_r;
	assign chip_reset_o          = chip_rst_r;
	assign receive_dma_restart_o = dma_rst_r;
	assign irq_o                 = irq_r;

	//////////////////////////////////////////////////////////////////////////
	// checks

	sequence s_rx_read;
		rd_rx_evt && !(|rx_set);
	endsequence

	a_event_read_clear: assert property (@(posedge clock_i) disable iff (srst_i)
		s_rx_read |=> rx_evt_r == '0) else $error("rx events not cleared by read");
	a_event_sticky: assert property (@(posedge clock_i) disable iff (srst_i)
		tx_evt_i.ok |=> tx_evt_r[TX_OK-6]) else $error("tx ok flag not set");
	a_act_once_pulse: assert property (@(posedge clock_i) disable iff (srst_i)
		chip_reset_o |=> !chip_reset_o) else $error("act-once held past one cycle");
	a_act_once_zero: assert property (@(posedge clock_i) disable iff (srst_i)
		!rx_cfg_r[ACT_ONCE_BIT-6] && !buf_cfg_r[ACT_ONCE_BIT-6]) else $error("act bit stored");
	a_irq_enabled: assert property (@(posedge clock_i) disable iff (srst_i)
		(rx_evt_r[RX_OK-6] && rx_cfg_r[RX_OK-6]) |=> irq_o) else $error("irq missing");
	a_irq_quiet: assert property (@(posedge clock_i) disable iff (srst_i)
		(!(|(rx_evt_r & rx_cfg_r)) && !(|(tx_evt_r & tx_cfg_r)) && !(|(buf_evt_r & buf_cfg_r))
		&& !swint_r) |=> !irq_o) else $error("irq without enabled event");
	a_drop_len: assert property (@(posedge clock_i) disable iff (srst_i)
		(rx_frame_done_i && !acc_now) |=> rx_len_o == 16'h0000 && !rx_accept_o)
		else $error("rejected frame kept length");
	a_counter_clear: assert property (@(posedge clock_i) disable iff (srst_i)
		(rd_miss && !missed_frame_i) |=> miss_cnt == '0) else $error("counter not cleared");
	a_overflow_flag: assert property (@(posedge clock_i) disable iff (srst_i)
		miss_ovf |=> buf_evt_r[BF_MOVF-6]) else $error("overflow not flagged");
	a_tx_start: assert property (@(posedge clock_i) disable iff (srst_i)
		wr_tx_cmd |=> tx_start_o ##1 !tx_start_o || wr_tx_cmd) else $error("tx start wrong");

endmodule

//--- logic/evt_pkg.sv
package evt_pkg;

	// register word layout
	localparam int REG_W        = 16;
	localparam int ID_W         = 6;
	localparam int ACT_ONCE_BIT = 6;
	localparam int CNT_W        = 10;
	localparam logic [CNT_W-1:0] CNT_WRAP = 10'h1ff;

	// byte offsets of the word registers on the bus
	localparam logic [7:0] OFF_RX_CFG   = 8'h00;
	localparam logic [7:0] OFF_RX_EVT   = 8'h04;
	localparam logic [7:0] OFF_RX_CTL   = 8'h08;
	localparam logic [7:0] OFF_TX_CFG   = 8'h0c;
	localparam logic [7:0] OFF_TX_EVT   = 8'h10;
	localparam logic [7:0] OFF_BUF_CFG  = 8'h14;
	localparam logic [7:0] OFF_BUF_EVT  = 8'h18;
	localparam logic [7:0] OFF_MISS_CNT = 8'h1c;
	localparam logic [7:0] OFF_COL_CNT  = 8'h20;
	localparam logic [7:0] OFF_TDR      = 8'h24;
	localparam logic [7:0] OFF_LINE_ST  = 8'h28;
	localparam logic [7:0] OFF_SELF_CTL = 8'h2c;
	localparam logic [7:0] OFF_SELF_ST  = 8'h30;
	localparam logic [7:0] OFF_BUS_CTL  = 8'h34;
	localparam logic [7:0] OFF_BUS_ST   = 8'h38;
	localparam logic [7:0] OFF_TX_CMD   = 8'h3c;

	// identification codes in bits 5:0; bit 0 marks config (1) or status (0)
	localparam logic [5:0] ID_RX_CFG   = 6'h03;
	localparam logic [5:0] ID_RX_EVT   = 6'h04;
	localparam logic [5:0] ID_RX_CTL   = 6'h05;
	localparam logic [5:0] ID_TX_CFG   = 6'h07;
	localparam logic [5:0] ID_TX_EVT   = 6'h08;
	localparam logic [5:0] ID_TX_CMD   = 6'h09;
	localparam logic [5:0] ID_BUF_CFG  = 6'h0b;
	localparam logic [5:0] ID_BUF_EVT  = 6'h0c;
	localparam logic [5:0] ID_MISS_CNT = 6'h10;
	localparam logic [5:0] ID_COL_CNT  = 6'h12;
	localparam logic [5:0] ID_LINE_ST  = 6'h14;
	localparam logic [5:0] ID_SELF_CTL = 6'h15;
	localparam logic [5:0] ID_SELF_ST  = 6'h16;
	localparam logic [5:0] ID_BUS_CTL  = 6'h17;
	localparam logic [5:0] ID_BUS_ST   = 6'h18;
	localparam logic [5:0] ID_TDR      = 6'h1c;

	// event bit positions (rx/tx/buffer), and enable positions match them
	localparam int RX_EXTRA = 14;
	localparam int RX_RUNT  = 13;
	localparam int RX_CRC   = 12;
	localparam int RX_OK    = 8;
	localparam int TX_CARR  = 6;
	localparam int TX_HBEAT = 7;
	localparam int TX_OK    = 8;
	localparam int TX_LATE  = 9;
	localparam int TX_JAB   = 10;
	localparam int TX_ANYC  = 11;
	localparam int TX_16C   = 15;
	localparam int BF_DMA   = 7;
	localparam int BF_RDY   = 8;
	localparam int BF_UNDR  = 9;
	localparam int BF_MISS  = 10;
	localparam int BF_128   = 11;
	localparam int BF_MOVF  = 12;
	localparam int BF_COVF  = 13;
	localparam int BF_DEST  = 15;

	// receive control: four class accepts at event positions, five filter accepts
	localparam int         FILT_LSB   = 6;
	localparam int         FILT_W     = 5;
	localparam logic [15:0] RX_CTL_MASK = 16'h7fc0;

	// reset values of the writable bits (6..15)
	localparam logic [9:0] CFG_RST = 10'h000;

	// bus request
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} bus_req_s;

	// frame and line events reported by the mac engine, one-cycle pulses
	typedef struct packed {
		logic extra;
		logic runt;
		logic crc;
		logic ok;
	} rx_evt_s;

	typedef struct packed {
		logic sixteen;
		logic anycol;
		logic jabber;
		logic late;
		logic ok;
		logic hbeat;
		logic carrier;
	} tx_evt_s;

	typedef struct packed {
		logic dest;
		logic first128;
		logic missed;
		logic underrun;
		logic rdy;
		logic dma;
	} buf_evt_s;

endpackage

//--- logic/evt_counter.sv
`timescale 1ns/1ps
// clear-on-read event counter; pulses ovf when passing the wrap value
module evt_counter
	import evt_pkg::*;
#(
	parameter int W = CNT_W
) (
	// clock and reset
	input  wire logic         clock_i,
	input  wire logic         srst_i,
	// count and read-clear
	input  wire logic         inc_i,
	input  wire logic         clr_i,
	// state
	output logic [W-1:0]      count_o,
	output logic              ovf_o
);

	logic [W-1:0] cnt_r;
	logic         ovf_r;
	wire          pass_wrap = inc_i && (cnt_r == W'(CNT_WRAP));

	// a count landing with the read-clear survives as one
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			cnt_r <= '0;
			ovf_r <= 1'b0;
		end else begin
			cnt_r <= clr_i ? W'(inc_i) : cnt_r + W'(inc_i);
			ovf_r <= pass_wrap;
		end
	end

	assign count_o = cnt_r;
	assign ovf_o   = ovf_r;

endmodule

//--- bench/host_model.sv
`timescale 1ns/1ps
// host side of the register bus, one word transfer per go pulse
module host_model
	import evt_pkg::*;
(
	// clock and reset
	input  wire logic        clock_i,
	input  wire logic        srst_i,
	// request from the bench
	input  wire bus_req_s    req_i,
	input  wire logic        go_i,
	output logic             done_o,
	output logic [15:0]      rdata_o,
	// avalon-mm master
	output logic [7:0]       avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic [31:0]      avs_writedata,
	output logic [3:0]       avs_byteenable,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest
);
	wire logic busy = avs_read | avs_write;

	initial begin
		{avs_read, avs_write, done_o, rdata_o} = '0;
		{avs_address, avs_writedata, avs_byteenable} = '1;
	end

	//////////////////////////////////////////////////////////////////////////
	// hold the request until waitrequest is low; released address and data lines flip so
	// that a slave latching them late cannot see the old value
	always @(posedge clock_i) begin
		done_o <= 1'b0;
		if (srst_i) begin
			avs_read  <= 1'b0;
			avs_write <= 1'b0;
		end else if (busy && !avs_waitrequest) begin
			rdata_o        <= avs_readdata[15:0];
			avs_read       <= 1'b0;
			avs_write      <= 1'b0;
			avs_address    <= ~avs_address;
			avs_writedata  <= ~avs_writedata;
			avs_byteenable <= 4'h0;
			done_o         <= 1'b1;
		end else if (go_i && !busy) begin
			avs_read       <= req_i.rd;
			avs_write      <= req_i.wr;
			avs_address    <= req_i.addr;
			avs_writedata  <= {16'h0000, req_i.wdata};
			avs_byteenable <= 4'h3;
		end
	end
endmodule

//--- bench/event_interrupt_bit_semantics_test.sv
`timescale 1ns/1ps
module event_interrupt_bit_semantics_test;
	import evt_pkg::*;
	localparam logic [7:0]  CO [4] = '{OFF_RX_CFG, OFF_TX_CFG, OFF_BUF_CFG, OFF_RX_CTL};
	localparam logic [5:0]  CI [4] = '{ID_RX_CFG, ID_TX_CFG, ID_BUF_CFG, ID_RX_CTL};
	localparam logic [15:0] CM [4] = '{16'h7140, 16'h8fc0, 16'hbfc0, RX_CTL_MASK};
	localparam logic [7:0]  EO [3] = '{OFF_RX_EVT, OFF_TX_EVT, OFF_BUF_EVT};
	localparam logic [5:0]  EI [3] = '{ID_RX_EVT, ID_TX_EVT, ID_BUF_EVT};
	localparam logic [15:0] EM [3] = '{16'h7100, 16'h8fc0, 16'h8f80};
	localparam logic [7:0]  SO [4] = '{OFF_LINE_ST, OFF_SELF_ST, OFF_BUS_ST, OFF_TDR};
	localparam logic [5:0]  SI [4] = '{ID_LINE_ST, ID_SELF_ST, ID_BUS_ST, ID_TDR};
	logic        clock_i, srst_i, go, done, rd, wr, wrq, miss, col, fdone;
	logic        racc, tstart, fskip, creset, dmarst, irq;
	logic [7:0]  adr;
	logic [3:0]  be;
	logic [31:0] wdat, rdat;
	logic [15:0] rd16, flen, rlen, tcmd, v;
	logic [9:0]  sv [4];
	logic [4:0]  filt;
	bus_req_s    req;
	rx_evt_s     rxe;
	tx_evt_s     txe;
	buf_evt_s    bfe;
	int          err_count, samples_checked, n_skip, n_crst, n_dma, n_tx, n_irq;
	logic [15:0] lfsr_q;

	host_model i_host (.clock_i(clock_i), .srst_i(srst_i), .req_i(req), .go_i(go),
		.done_o(done), .rdata_o(rd16), .avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
		.avs_waitrequest(wrq));
	evt_ctrl i_dut (.clock_i(clock_i), .srst_i(srst_i), .avs_address(adr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
		.avs_waitrequest(wrq), .rx_evt_i(rxe), .tx_evt_i(txe), .buf_evt_i(bfe),
		.missed_frame_i(miss), .collision_i(col), .cable_reflectometer_i(sv[3]),
		.line_status_i(sv[0]), .self_status_i(sv[1]), .bus_status_i(sv[2]),
		.rx_frame_done_i(fdone), .rx_frame_len_i(flen), .rx_accept_o(racc),
		.rx_len_o(rlen), .addr_filter_accept_o(filt), .tx_start_o(tstart),
		.tx_command_o(tcmd), .frame_skip_o(fskip), .chip_reset_o(creset),
		.receive_dma_restart_o(dmarst), .irq_o(irq));

	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end

	//////////////////////////////////////////////////////////////////////////
	// pulse tallies for the single-cycle action outputs and cycles with the interrupt high
	always @(posedge clock_i) begin
		if (fskip === 1'b1) n_skip++;
		if (creset === 1'b1) n_crst++;
		if (dmarst === 1'b1) n_dma++;
		if (tstart === 1'b1) n_tx++;
		if (irq === 1'b1) n_irq++;
	end

	function logic [15:0] nx();
		lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
		return lfsr_q;
	endfunction
	// expected word: data in 15:6, register code in 5:0
	function logic [31:0] wd(input logic [5:0] id, input logic [15:0] d);
		return {16'h0000, d[15:6], id};
	endfunction
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task close_out();
		$display("errors %0d of %0d compares", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task bus(input logic r, input logic [7:0] a, input logic [15:0] d);
		int n;
		@(posedge clock_i);
		req <= '{rd: r, wr: !r, addr: a, wdata: d};
		go  <= 1'b1;
		@(posedge clock_i);
		go <= 1'b0;
		n = 0;
		do begin
			@(posedge clock_i);
			#1 n++;
		end while (done !== 1'b1 && n < 50);
		if (n >= 50) chk(1, 0);
	endtask
	// one-cycle event pulses; a receive pulse also closes a frame
	task ev(input rx_evt_s r, input tx_evt_s t, input buf_evt_s b, input logic m, c);
		@(posedge clock_i);
		{rxe, txe, bfe, miss, col, fdone} <= {r, t, b, m, c, |r};
		@(posedge clock_i);
		{rxe, txe, bfe, miss, col, fdone} <= '0;
		repeat (3) @(posedge clock_i);
		#1;
	endtask

	initial begin
		#100000 err_count++;
		close_out();
	end

	initial begin
		srst_i = 1'b1;
		{go, req, rxe, txe, bfe, miss, col, fdone} = '0;
		{err_count, samples_checked, n_skip, n_crst, n_dma, n_tx, n_irq} = '0;
		lfsr_q = 16'd3422;
		flen = nx();
		foreach (sv[i]) sv[i] = nx();
		repeat (20) @(posedge clock_i);
		srst_i <= 1'b0;
		bus(1, CO[0], 0); chk(rd16, wd(ID_RX_CFG, {CFG_RST, 6'h00}));
		bus(1, 8'h40, 0); chk(rd16, 0);
		// configuration words: random data, act-once bit 6 reads back clear in receive and buffer config
		foreach (CO[i]) begin
			v = nx() & CM[i];
			bus(0, CO[i], v | 16'h0040);
			bus(1, CO[i], 0);
			chk(rd16, wd(CI[i], (v | 16'h0040) & (i % 2 ? 16'hffff : 16'hffbf)));
		end
		chk(filt, {v[11:9], v[7], 1'b1});
		chk(n_skip, 1);
		chk(n_irq > 0, 1);
		repeat (2) bus(0, OFF_SELF_CTL, 16'h0040);
		repeat (2) bus(0, OFF_BUS_CTL, 16'h0040);
		bus(1, OFF_BUS_CTL, 0); chk(rd16, wd(ID_BUS_CTL, 0));
		chk(n_crst, 2);
		chk(n_dma, 2);
		foreach (CO[i]) bus(0, CO[i], 0);
		// status words follow the hardware, host writes have no effect
		foreach (SO[i]) begin
			bus(0, SO[i], nx());
			bus(1, SO[i], 0); chk(rd16, wd(SI[i], {sv[i], 6'h00}));
		end
		ev('1, '1, '1, 0, 0); chk(irq, 0);
		foreach (EO[i]) begin
			bus(0, CO[i], EM[i]);
			ev('1, '1, '1, 0, 0); chk(irq, 1);
			bus(1, EO[i], 0); chk(rd16, wd(EI[i], EM[i]));
			bus(1, EO[i], 0); chk(rd16, wd(EI[i], 0));
			#6 chk(irq, 0);
			bus(0, CO[i], 0);
		end
		// counters clear on read; the 512th count passes 1ffh
		repeat (5) ev(0, 0, 0, 1, 1);
		bus(1, OFF_MISS_CNT, 0); chk(rd16, wd(ID_MISS_CNT, 16'h0140));
		bus(1, OFF_COL_CNT, 0); chk(rd16, wd(ID_COL_CNT, 16'h0140));
		bus(1, OFF_COL_CNT, 0); chk(rd16, wd(ID_COL_CNT, 0));
		bus(1, OFF_MISS_CNT, 0);
		bus(0, OFF_BUF_CFG, 16'h1000);
		repeat (511) ev(0, 0, 0, 1, 0);
		chk(irq, 0);
		ev(0, 0, 0, 1, 0); chk(irq, 1);
		bus(1, OFF_MISS_CNT, 0); chk(rd16, wd(ID_MISS_CNT, {CNT_WRAP + 10'h001, 6'h00}));
		bus(1, OFF_BUF_EVT, 0); chk(rd16, wd(ID_BUF_EVT, 16'h1000));
		bus(0, OFF_BUF_CFG, 0);
		// frames with accept set, then enable set with accept clear
		for (int p = 0; p < 2; p++) begin
			bus(0, OFF_RX_CTL, p ? 16'h0000 : 16'h0100);
			bus(0, OFF_RX_CFG, p ? 16'h0100 : 16'h0000);
			flen = nx();
			ev(4'b0001, 0, 0, 0, 0);
			chk({racc, rlen, irq}, p ? 18'h0_0001 : {1'b1, flen, 1'b0});
			bus(1, OFF_RX_EVT, 0);
		end
		// each command write starts exactly one send
		v = nx();
		bus(0, OFF_TX_CMD, nx());
		bus(0, OFF_TX_CMD, v);
		chk(n_tx, 2);
		chk(tcmd, v);
		close_out();
	end
endmodule
